// ### design/i2c_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef I2C_DEFS_SVH
`define I2C_DEFS_SVH

`define CTRL_OFFSET 8'h00
`define STAT_OFFSET 8'h04
`define TXD_OFFSET 8'h08

`define EN_BIT 15
`define SIDL_BIT 13
`define REL_BIT 12
`define RECEIVE_STRETCH_ENABLE_BIT 6

`define CTRL_RESET 16'h1000
`define CTRL_LOW_MASK 12'h0fff

`define STAT_TBF_BIT 8
`define STAT_RXFULL_BIT 9
`define STAT_HELD_BIT 10
`define STAT_PRIMARY_BIT 11

`define LAST_BIT_CNT 4'h8
`define DATA_LAST_CNT 4'h7
`define START_CNT 4'hf

`endif

// ### design/i2c_pkg.sv
// types shared by the serial bus slave files
package i2c_pkg;

	typedef enum logic [2:0] {
		LINK_IDLE,
		LINK_ADDR,
		LINK_RX,
		LINK_TX,
		LINK_WAIT
	} link_state_type;

endpackage

// ### design/sync2.sv
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_q;

	// only the second stage is visible outside
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RESET_VAL;
			dout <= RESET_VAL;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end

endmodule

// ### design/pin_route.sv
// steers the open-drain data and clock lines to one of two pin pairs
`timescale 1ns/1ps
module pin_route (
	input wire logic use_primary,
	input wire logic scl_pull,
	input wire logic sda_pull,
	output logic scl_in,
	output logic sda_in,
	input wire logic primary_clock_pin_i,
	output logic primary_clock_pin_o,
	output logic primary_clock_pin_oe,
	input wire logic primary_data_pin_i,
	output logic primary_data_pin_o,
	output logic primary_data_pin_oe,
	input wire logic alternate_clock_pin_i,
	output logic alternate_clock_pin_o,
	output logic alternate_clock_pin_oe,
	input wire logic alternate_data_pin_i,
	output logic alternate_data_pin_o,
	output logic alternate_data_pin_oe
);

	// open drain: only ever drive low
	assign primary_clock_pin_o = 1'b0;
	assign primary_data_pin_o = 1'b0;
	assign alternate_clock_pin_o = 1'b0;
	assign alternate_data_pin_o = 1'b0;

	assign primary_clock_pin_oe = use_primary & scl_pull;
	assign primary_data_pin_oe = use_primary & sda_pull;
	assign alternate_clock_pin_oe = ~use_primary & scl_pull;
	assign alternate_data_pin_oe = ~use_primary & sda_pull;

	assign scl_in = use_primary ? primary_clock_pin_i : alternate_clock_pin_i;
	assign sda_in = use_primary ? primary_data_pin_i : alternate_data_pin_i;

endmodule

// ### design/i2c_pin_route_and_clock_release.sv
// two-wire slave with pin routing, clock release control and ahb-lite registers
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "i2c_defs.svh"

module i2c_pin_route_and_clock_release
	import i2c_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic link_clk,
	input wire logic alt_pin_route_select,
	input wire logic primary_clock_pin_i,
	output logic primary_clock_pin_o,
	output logic primary_clock_pin_oe,
	input wire logic primary_data_pin_i,
	output logic primary_data_pin_o,
	output logic primary_data_pin_oe,
	input wire logic alternate_clock_pin_i,
	output logic alternate_clock_pin_o,
	output logic alternate_clock_pin_oe,
	input wire logic alternate_data_pin_i,
	output logic alternate_data_pin_o,
	output logic alternate_data_pin_oe
);

	// host side state
	logic module_enable_q, halt_in_idle_q, clock_release_ctl_q;
	logic [11:0] ctrl_low_q;
	logic transmit_buffer_full_q, rx_full_q, wr_pend_q, route_primary_q;
	logic [7:0] tx_q, rx_q, addr_q;
	logic [31:0] hrdata_q;
	logic [1:0] strap_cnt_q;
	logic strap_s;
	logic [2:0] evt_s, evt_p_q;
	logic stretch_evt, rx_evt, used_evt;
	logic acc, ctrl_wr, txd_wr, stat_rd;
	logic [15:0] ctrl_rd, stat_rd_val;

	// link side state
	logic lrst_n;
	logic [3:0] host_s;
	logic en_s, receive_stretch_enable_s, tbf_s, rel_s;
	logic scl_raw, sda_raw, scl_s, sda_s, scl_p_q, sda_p_q;
	logic [1:0] pin_s;
	logic start_c, stop_c, rise_c, fall_c;
	link_state_type state_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q, rx_byte_q, tx_shift_q;
	logic loaded_q, mack_q, sda_oe_q, hold_q;
	logic stretch_tgl_q, rx_tgl_q, used_tgl_q;
	logic scl_pull;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	// strap is a pin level, caught once after reset release
	sync2 #(.WIDTH(1), .RESET_VAL(1'b1)) u_strap_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.din(alt_pin_route_select),
		.dout(strap_s)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_cnt_q <= 2'h0;
			route_primary_q <= 1'b1;
		end else if (strap_cnt_q != 2'h3) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			// first two counts only flush the synchroniser's reset value
			if (strap_cnt_q == 2'h2) begin
				route_primary_q <= strap_s;
			end
		end
	end

	// ahb-lite address phase; zero wait states so hready is always ours
	assign acc = hsel & hready & htrans[1];
	assign ctrl_wr = wr_pend_q & (addr_q == `CTRL_OFFSET);
	assign txd_wr = wr_pend_q & (addr_q == `TXD_OFFSET);
	assign stat_rd = acc & ~hwrite & (haddr[7:0] == `STAT_OFFSET);

	assign ctrl_rd = {module_enable_q, 1'b0, halt_in_idle_q, clock_release_ctl_q, ctrl_low_q};
	assign stat_rd_val = {4'h0, route_primary_q, ~clock_release_ctl_q & module_enable_q,
		rx_full_q, transmit_buffer_full_q, rx_q};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			wr_pend_q <= acc & hwrite;
			if (acc) begin
				addr_q <= haddr[7:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (acc & ~hwrite) begin
			case (haddr[7:0])
				`CTRL_OFFSET: hrdata_q <= {16'h0000, ctrl_rd};
				`STAT_OFFSET: hrdata_q <= {16'h0000, stat_rd_val};
				`TXD_OFFSET: hrdata_q <= {24'h00_0000, tx_q};
				default: hrdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// plain control bits; master sequencing bits are storage only here
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			module_enable_q <= 1'(`CTRL_RESET >> `EN_BIT);
			halt_in_idle_q <= 1'b0;
			ctrl_low_q <= 12'h000;
		end else if (ctrl_wr) begin
			module_enable_q <= hwdata[`EN_BIT];
			halt_in_idle_q <= hwdata[`SIDL_BIT];
			ctrl_low_q <= hwdata[11:0] & `CTRL_LOW_MASK;
		end
	end

	// hardware clear beats a same-cycle software release, so no stretch is lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_release_ctl_q <= 1'b1;
		end else if (stretch_evt) begin
			clock_release_ctl_q <= 1'b0;
		end else if (ctrl_wr) begin
			if (ctrl_low_q[`RECEIVE_STRETCH_ENABLE_BIT]) begin
				clock_release_ctl_q <= hwdata[`REL_BIT];
			end else if (hwdata[`REL_BIT]) begin
				// without receive stretch software may only release
				clock_release_ctl_q <= 1'b1;
			end
		end
	end

	// tx byte only accepted while empty, keeps it stable for the link side
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			transmit_buffer_full_q <= 1'b0;
			tx_q <= 8'h00;
		end else if (txd_wr & ~transmit_buffer_full_q) begin
			transmit_buffer_full_q <= 1'b1;
			tx_q <= hwdata[7:0];
		end else if (used_evt) begin
			transmit_buffer_full_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_q <= 8'h00;
			rx_full_q <= 1'b0;
		end else if (rx_evt) begin
			rx_q <= rx_byte_q;
			rx_full_q <= 1'b1;
		end else if (stat_rd) begin
			rx_full_q <= 1'b0;
		end
	end

	// link events arrive as toggles
	sync2 #(.WIDTH(3), .RESET_VAL(3'b000)) u_evt_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.din({stretch_tgl_q, rx_tgl_q, used_tgl_q}),
		.dout(evt_s)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			evt_p_q <= 3'b000;
		end else begin
			evt_p_q <= evt_s;
		end
	end

	assign stretch_evt = evt_s[2] ^ evt_p_q[2];
	assign rx_evt = evt_s[1] ^ evt_p_q[1];
	assign used_evt = evt_s[0] ^ evt_p_q[0];

	// link reset: asserted with hresetn, released on link_clk
	sync2 #(.WIDTH(1), .RESET_VAL(1'b0)) u_lrst_sync (
		.clk(link_clk),
		.rst_n(hresetn),
		.din(1'b1),
		.dout(lrst_n)
	);

	sync2 #(.WIDTH(4), .RESET_VAL(4'b0001)) u_host_sync (
		.clk(link_clk),
		.rst_n(lrst_n),
		.din({module_enable_q, ctrl_low_q[`RECEIVE_STRETCH_ENABLE_BIT], transmit_buffer_full_q,
			clock_release_ctl_q}),
		.dout(host_s)
	);

	assign en_s = host_s[3];
	assign receive_stretch_enable_s = host_s[2];
	assign tbf_s = host_s[1];
	assign rel_s = host_s[0];

	pin_route u_route (
		.use_primary(route_primary_q),
		.scl_pull(scl_pull),
		.sda_pull(sda_oe_q),
		.scl_in(scl_raw),
		.sda_in(sda_raw),
		.primary_clock_pin_i(primary_clock_pin_i),
		.primary_clock_pin_o(primary_clock_pin_o),
		.primary_clock_pin_oe(primary_clock_pin_oe),
		.primary_data_pin_i(primary_data_pin_i),
		.primary_data_pin_o(primary_data_pin_o),
		.primary_data_pin_oe(primary_data_pin_oe),
		.alternate_clock_pin_i(alternate_clock_pin_i),
		.alternate_clock_pin_o(alternate_clock_pin_o),
		.alternate_clock_pin_oe(alternate_clock_pin_oe),
		.alternate_data_pin_i(alternate_data_pin_i),
		.alternate_data_pin_o(alternate_data_pin_o),
		.alternate_data_pin_oe(alternate_data_pin_oe)
	);

	sync2 #(.WIDTH(2), .RESET_VAL(2'b11)) u_pin_sync (
		.clk(link_clk),
		.rst_n(lrst_n),
		.din({scl_raw, sda_raw}),
		.dout(pin_s)
	);

	assign scl_s = pin_s[1];
	assign sda_s = pin_s[0];

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign rise_c = scl_s & ~scl_p_q;
	assign fall_c = ~scl_s & scl_p_q;

	// local hold covers the gap until the host bit has been cleared
	assign scl_pull = en_s & (hold_q | ~rel_s);

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			state_q <= LINK_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			rx_byte_q <= 8'h00;
			tx_shift_q <= 8'hff;
			loaded_q <= 1'b0;
			mack_q <= 1'b0;
			sda_oe_q <= 1'b0;
			hold_q <= 1'b0;
			stretch_tgl_q <= 1'b0;
			rx_tgl_q <= 1'b0;
			used_tgl_q <= 1'b0;
		end else if (!en_s) begin
			state_q <= LINK_IDLE;
			sda_oe_q <= 1'b0;
			hold_q <= 1'b0;
		end else if (start_c) begin
			state_q <= LINK_ADDR;
			bit_cnt_q <= `START_CNT; // start's own clock fall wraps this to zero
			sda_oe_q <= 1'b0;
		end else if (stop_c) begin
			state_q <= LINK_IDLE;
			sda_oe_q <= 1'b0;
		end else begin
			hold_q <= hold_q & rel_s;
			if (rise_c && state_q != LINK_IDLE && state_q != LINK_WAIT) begin
				if (bit_cnt_q != `LAST_BIT_CNT) begin
					shift_q <= {shift_q[6:0], sda_s};
				end else begin
					mack_q <= ~sda_s;
				end
			end
			// next byte is fetched while the clock is low
			if (state_q == LINK_TX && bit_cnt_q == 4'h0 && !scl_s && !loaded_q && tbf_s) begin
				tx_shift_q <= tx_q;
				loaded_q <= 1'b1;
				used_tgl_q <= ~used_tgl_q;
				sda_oe_q <= ~tx_q[7];
			end
			if (fall_c && state_q != LINK_IDLE && state_q != LINK_WAIT) begin
				if (bit_cnt_q == `LAST_BIT_CNT) begin
					bit_cnt_q <= 4'h0;
					sda_oe_q <= 1'b0;
					case (state_q)
						LINK_ADDR: begin
							if (shift_q[0]) begin
								state_q <= LINK_TX;
								loaded_q <= 1'b0;
								if (receive_stretch_enable_s | ~tbf_s) begin
									hold_q <= 1'b1;
									stretch_tgl_q <= ~stretch_tgl_q;
								end
							end else begin
								state_q <= LINK_RX;
							end
						end
						LINK_RX: begin
							rx_byte_q <= shift_q;
							rx_tgl_q <= ~rx_tgl_q;
							if (receive_stretch_enable_s) begin
								hold_q <= 1'b1;
								stretch_tgl_q <= ~stretch_tgl_q;
							end
						end
						LINK_TX: begin
							loaded_q <= 1'b0;
							if (!mack_q) begin
								state_q <= LINK_WAIT;
							end else if (!tbf_s) begin
								hold_q <= 1'b1;
								stretch_tgl_q <= ~stretch_tgl_q;
							end
						end
						default: begin
							state_q <= LINK_IDLE;
						end
					endcase
				end else begin
					bit_cnt_q <= bit_cnt_q + 4'h1;
					if (bit_cnt_q == `DATA_LAST_CNT) begin
						// acknowledge address and written bytes, free the line for master ack
						sda_oe_q <= (state_q != LINK_TX);
					end else if (state_q == LINK_TX) begin
						tx_shift_q <= {tx_shift_q[6:0], 1'b1};
						sda_oe_q <= ~tx_shift_q[6];
					end
				end
			end
		end
	end

endmodule

// ### tb/clk_rel_chk_sva.sv
// concurrent checks on the serial slave ports
`timescale 1ns/1ps
`include "i2c_defs.svh"
module clk_rel_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic link_clk,
	input wire logic alt_pin_route_select,
	input wire logic primary_clock_pin_o,
	input wire logic primary_clock_pin_oe,
	input wire logic primary_data_pin_oe,
	input wire logic alternate_clock_pin_o,
	input wire logic alternate_clock_pin_oe,
	input wire logic alternate_data_pin_oe
);
	logic take, any_oe, wr_q, rd_q, receive_stretch_enable_q;
	assign take = hsel && hready && htrans[1] && haddr[7:0] == `CTRL_OFFSET;
	assign any_oe = primary_clock_pin_oe || alternate_clock_pin_oe;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			wr_q <= take && hwrite;
			rd_q <= take && !hwrite;
		end
	end
	// the enable already stored decides whether a zero write may hold
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			receive_stretch_enable_q <= 1'b0;
		end else if (wr_q) begin
			receive_stretch_enable_q <= hwdata[`RECEIVE_STRETCH_ENABLE_BIT];
		end
	end
	chk_route_primary: assert property (@(posedge link_clk) disable iff (!hresetn)
		alt_pin_route_select |-> !alternate_clock_pin_oe && !alternate_data_pin_oe)
		else $error("alternate pins driven on primary route");
	chk_route_alt: assert property (@(posedge link_clk) disable iff (!hresetn)
		!alt_pin_route_select |-> !primary_clock_pin_oe && !primary_data_pin_oe)
		else $error("primary pins driven on alternate route");
	chk_one_pair: assert property (@(posedge hclk) disable iff (!hresetn)
		!(primary_clock_pin_oe && alternate_clock_pin_oe))
		else $error("both clock pins driven");
	chk_clock_low: assert property (@(posedge link_clk) disable iff (!hresetn)
		!(primary_clock_pin_oe && primary_clock_pin_o)
		&& !(alternate_clock_pin_oe && alternate_clock_pin_o))
		else $error("clock pin driven high");
	chk_release_frees: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_q && hwdata[`REL_BIT] |-> ##[1:12] !any_oe)
		else $error("clock still held after release write");
	chk_sw_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_q && receive_stretch_enable_q && hwdata[`EN_BIT] && hwdata[`RECEIVE_STRETCH_ENABLE_BIT] && !hwdata[`REL_BIT]
		|-> ##[2:20] any_oe)
		else $error("zero release write did not hold clock");
	chk_stretch_stays: assert property (@(posedge link_clk) disable iff (!hresetn)
		$rose(any_oe) |=> any_oe [*6])
		else $error("clock stretch ended early");
	chk_ctrl_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_q |-> hrdata[31:16] == 16'h0000 && !hrdata[14])
		else $error("control upper bits not zero");
	cover property (@(posedge link_clk) disable iff (!hresetn) $rose(primary_clock_pin_oe));
	cover property (@(posedge link_clk) disable iff (!hresetn) $rose(alternate_clock_pin_oe));
	cover property (@(posedge hclk) disable iff (!hresetn) rd_q);
endmodule

bind i2c_pin_route_and_clock_release clk_rel_chk chk_u (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.link_clk(link_clk), .alt_pin_route_select(alt_pin_route_select),
	.primary_clock_pin_o(primary_clock_pin_o), .primary_clock_pin_oe(primary_clock_pin_oe),
	.primary_data_pin_oe(primary_data_pin_oe), .alternate_clock_pin_o(alternate_clock_pin_o),
	.alternate_clock_pin_oe(alternate_clock_pin_oe),
	.alternate_data_pin_oe(alternate_data_pin_oe)
);

// ### tb/bus_master_model.sv
// behavioural two-wire bus master on open-drain lines
`timescale 1ns/1ps
module bus_master_model (
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_oe,
	output logic sda_oe
);
	int stalls;
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		stalls = 0;
	end
	// a slave may stretch, so the high phase starts only once seen high
	task automatic rise();
		int n;
		scl_oe = 1'b0;
		n = 0;
		while (scl_in !== 1'b1 && n < 400) begin
			#10;
			n++;
		end
		if (scl_in !== 1'b1) stalls++;
		#100;
	endtask
	task automatic start();
		sda_oe = 1'b1;
		#100;
		scl_oe = 1'b1;
		#100;
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_oe = !b;
		#100;
		rise();
		r = sda_in;
		scl_oe = 1'b1;
	endtask
	task automatic xfer(input logic [7:0] tx, input logic ack_in,
		output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(ack_in, ack);
	endtask
	task automatic stop();
		scl_oe = 1'b1;
		#100;
		sda_oe = 1'b1;
		#100;
		rise();
		sda_oe = 1'b0;
		#100;
	endtask
endmodule

// ### tb/i2c_pin_route_and_clock_release_tb.sv
// testbench for the serial slave with clock release control
`timescale 1ns/1ps
`include "i2c_defs.svh"
module i2c_pin_route_and_clock_release_tb;
	logic hclk, hresetn, hsel, hwrite, link_clk, route_sel, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic pc_o, pc_oe, pd_o, pd_oe, ac_o, ac_oe, ad_o, ad_oe, m_scl, m_sda;
	logic pc_i, pd_i, ac_i, ad_i, scl, sda, held;
	int error_cnt, tests_run;
	assign pc_i = !(pc_oe || (route_sel && m_scl));
	assign pd_i = !(pd_oe || (route_sel && m_sda));
	assign ac_i = !(ac_oe || (!route_sel && m_scl));
	assign ad_i = !(ad_oe || (!route_sel && m_sda));
	assign scl = route_sel ? pc_i : ac_i;
	assign sda = route_sel ? pd_i : ad_i;
	assign held = route_sel ? pc_oe : ac_oe;
	i2c_pin_route_and_clock_release dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk),
		.alt_pin_route_select(route_sel), .primary_clock_pin_i(pc_i),
		.primary_clock_pin_o(pc_o), .primary_clock_pin_oe(pc_oe),
		.primary_data_pin_i(pd_i), .primary_data_pin_o(pd_o), .primary_data_pin_oe(pd_oe),
		.alternate_clock_pin_i(ac_i), .alternate_clock_pin_o(ac_o),
		.alternate_clock_pin_oe(ac_oe), .alternate_data_pin_i(ad_i),
		.alternate_data_pin_o(ad_o), .alternate_data_pin_oe(ad_oe)
	);
	bus_master_model master_u (.scl_in(scl), .sda_in(sda), .scl_oe(m_scl), .sda_oe(m_sda));
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = !hclk;
	end
	initial begin
		link_clk = 1'b0;
		#3.7;
		forever #6 link_clk = !link_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, exp);
	endtask
	task automatic settle(input logic v);
		int n;
		n = 0;
		while (held !== v && n < 100) begin
			@(posedge hclk);
			n++;
		end
		chk(held, v);
		// host copy of the release bit trails the pin by a few cycles
		repeat (4) @(posedge hclk);
	endtask
	task automatic do_reset(input logic sel);
		hresetn <= 1'b0;
		route_sel <= sel;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
	endtask
	task automatic t_regs();
		rdchk(`CTRL_OFFSET, 32'h0000_1000);
		chk({pc_o, pd_o, ac_o, ad_o, hresp, hreadyout}, 32'h0000_0001);
		rdchk(8'h0c, 32'h0000_0000);
		rdchk(`STAT_OFFSET, 32'h0000_0800);
		wr(`CTRL_OFFSET, 32'hffff_ffff);
		rdchk(`CTRL_OFFSET, 32'h0000_bfff);
		wr(`CTRL_OFFSET, 32'h0000_1000);
		wr(`CTRL_OFFSET, 32'h0000_0000);
		rdchk(`CTRL_OFFSET, 32'h0000_1000);
		$display("register access done");
	endtask
	task automatic t_sw();
		wr(`CTRL_OFFSET, 32'h0000_9040);
		wr(`CTRL_OFFSET, 32'h0000_8040);
		settle(1'b1);
		rdchk(`STAT_OFFSET, 32'h0000_0c00);
		wr(`CTRL_OFFSET, 32'h0000_9040);
		settle(1'b0);
		$display("software stretch done");
	endtask
	task automatic t_rx();
		logic [7:0] rx;
		logic ack;
		wr(`CTRL_OFFSET, 32'h0000_9000);
		master_u.start();
		master_u.xfer(8'h84, 1'b1, rx, ack);
		chk(ack, 1'b0);
		wr(`CTRL_OFFSET, 32'h0000_9040);
		master_u.xfer(8'h3c, 1'b1, rx, ack);
		chk(ack, 1'b0);
		settle(1'b1);
		rdchk(`CTRL_OFFSET, 32'h0000_8040);
		rdchk(`STAT_OFFSET, {20'h0_0000, route_sel, 11'h63c});
		wr(`CTRL_OFFSET, 32'h0000_9040);
		settle(1'b0);
		master_u.stop();
		chk(master_u.stalls, 32'h0000_0000);
		$display("receive stretch done");
	endtask
	task automatic t_tx();
		logic [7:0] rx;
		logic ack;
		for (int s = 0; s < 2; s++) begin
			wr(`CTRL_OFFSET, 32'h0000_9000 | (s << 6));
			master_u.start();
			master_u.xfer(8'h85, 1'b1, rx, ack);
			chk(ack, 1'b0);
			settle(1'b1);
			rdchk(`CTRL_OFFSET, 32'h0000_8000 | (s << 6));
			wr(`TXD_OFFSET, 32'h0000_00a5 ^ s);
			wr(`CTRL_OFFSET, 32'h0000_9000 | (s << 6));
			master_u.xfer(8'hff, 1'b1, rx, ack);
			chk(rx, 32'h0000_00a5 ^ s);
			master_u.stop();
			chk(master_u.stalls, 32'h0000_0000);
		end
		$display("transmit stretch done");
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		error_cnt++;
		close_out();
	end
	initial begin
		error_cnt = 0;
		tests_run = 0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		hresetn = 1'b0;
		route_sel = 1'b1;
		do_reset(1'b1);
		t_regs();
		t_sw();
		t_rx();
		t_tx();
		do_reset(1'b0);
		rdchk(`STAT_OFFSET, 32'h0000_0000);
		t_rx();
		close_out();
	end
endmodule
